// ===== hw/lpsw_params.svh
// Constants of the low-power port sampler with analog wake-up.
// Assumes one 125 MHz system clock and a 32-bit AXI4-Lite register port.
`ifndef LPSW_PARAMS_SVH
`define LPSW_PARAMS_SVH

`define LPSW_CLK_KHZ      125000
`define LPSW_HSOSC_KHZ    8000
`define LPSW_OSC_DIV      20
`define LPSW_STAB_SHIFT   4
`define LPSW_DIG_STAB_US  50
`define LPSW_ANA_STAB_US  100

`define LPSW_ADDR_W       8
`define LPSW_PORT_W       24
`define LPSW_TMR_N        8
`define LPSW_SG_N         5
`define LPSW_SG_FIRST     14
`define LPSW_CNT_W        20

`define LPSW_OFF_STAB     8'h00
`define LPSW_OFF_SEQ      8'h04
`define LPSW_OFF_OPST     8'h08
`define LPSW_OFF_MASK1    8'h0C
`define LPSW_OFF_MASK2    8'h10
`define LPSW_OFF_FACT1    8'h14
`define LPSW_OFF_FACT2    8'h18
`define LPSW_OFF_CLR1     8'h1C
`define LPSW_OFF_CLR2     8'h20
`define LPSW_OFF_HOLD1    8'h24
`define LPSW_OFF_HOLD2    8'h28
`define LPSW_OFF_PSC      8'h2C
`define LPSW_OFF_EXPECT   8'h30
`define LPSW_OFF_CAPT     8'h34

`define LPSW_BIT_COUNT_LO 8
`define LPSW_BIT_SEL_HI   7
`define LPSW_BIT_SEL_LO   2
`define LPSW_BIT_DIG_EN   1
`define LPSW_BIT_ANA_EN   0
`define LPSW_BIT_SMP_WAKE 1
`define LPSW_MASK_RESET   32'hFFFF_FFFF
`define LPSW_RESP_OKAY    2'h0
`define LPSW_RESP_SLVERR  2'h2

`endif

// ===== hw/lpsw_pkg.sv
// Types of the low-power port sampler with analog wake-up.
// Assumes lpsw_params.svh is on the include path.
`include "lpsw_params.svh"

package lpsw_pkg;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ARMED, SEQ_SETTLE} lpsw_seq_t;

  typedef struct packed {
    logic                      awvalid;
    logic [`LPSW_ADDR_W-1:0]   awaddr;
    logic                      wvalid;
    logic [31:0]               wdata;
    logic [3:0]                wstrb;
    logic                      bready;
    logic                      arvalid;
    logic [`LPSW_ADDR_W-1:0]   araddr;
    logic                      rready;
  } lpsw_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } lpsw_axi_rsp_t;

  typedef struct packed {
    lpsw_seq_t                seq;
    logic [7:0]               stabCount;
    logic                     selHi;
    logic [1:0]               selLo;
    logic                     digEn;
    logic                     anaEn;
    logic [31:0]              maskFirst;
    logic [31:0]              maskSecond;
    logic [31:0]              factFirst;
    logic [31:0]              factSecond;
    logic                     holdFirst;
    logic                     holdSecond;
    logic                     deep_stop_mode;
    logic [`LPSW_PORT_W-1:0]  expected;
    logic [`LPSW_PORT_W-1:0]  captured;
    logic [`LPSW_PORT_W-1:0]  portMeta;
    logic [`LPSW_PORT_W-1:0]  portSync;
    logic                     digDone;
    logic                     adcStarted;
    logic                     adcDoneSeen;
    logic                     mismatch;
    logic                     unexpected;
    logic                     digPwr;
    logic                     anaPwr;
    logic                     adcTrig;
    logic [15:0]              oscDiv;
    logic [15:0]              ticks;
    logic [`LPSW_CNT_W-1:0]   elapsed;
    logic                     awHeld;
    logic [`LPSW_ADDR_W-1:0]  awAddr;
    logic                     wHeld;
    logic [31:0]              wData;
    logic [3:0]               wStrb;
    logic                     bValid;
    logic [1:0]               bResp;
    logic                     rValid;
    logic [31:0]              rData;
    logic [1:0]               rResp;
  } lpsw_state_t;

endpackage

// ===== hw/lpsw_top.sv
// Low-power port sampler: cyclic supply, settle, compare, A/D trigger, wake factors.
// Assumes timer, A/D and scan-group inputs are on sys_clk; the port pins are not.
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`include "lpsw_params.svh"
`timescale 1ns/1ns
`default_nettype none

module lpsw_top #(
  parameter int DIG_STAB_CYC = (`LPSW_DIG_STAB_US * `LPSW_CLK_KHZ + 999) / 1000,
  parameter int OSC_TICK_CYC = (`LPSW_CLK_KHZ * `LPSW_OSC_DIV + `LPSW_HSOSC_KHZ - 1)
                               / `LPSW_HSOSC_KHZ
) (
  input  wire logic                     sys_clk,
  input  wire logic                     srst,
  input  wire lpsw_pkg::lpsw_axi_req_t  axiReq,
  output lpsw_pkg::lpsw_axi_rsp_t       axiRsp,
  input  wire logic [`LPSW_PORT_W-1:0]  portIn,
  input  wire logic [`LPSW_TMR_N-1:0]   timerTrig,
  input  wire logic                     adcDone,
  input  wire logic                     adcUnexpected,
  input  wire logic [`LPSW_SG_N-1:0]    scanGroupEndIrq,
  output logic                          digitalPowerOut,
  output logic                          analogPowerOut,
  output logic                          adcTrigger,
  output logic                          deepStopMode,
  output logic                          ioHoldFirst,
  output logic                          ioHoldSecond,
  output logic                          wakeRequest
);

  localparam logic [`LPSW_CNT_W-1:0] DIG_T  = `LPSW_CNT_W'(DIG_STAB_CYC);
  localparam logic [15:0]            TICK_T = 16'(OSC_TICK_CYC - 1);

  lpsw_pkg::lpsw_state_t q;
  lpsw_pkg::lpsw_state_t d;

  // Applies the write strobes lane by lane, so a narrow write leaves the
  // other bytes of a register as they were.
  function automatic logic [31:0] merge(input logic [31:0] oldV,
                                        input logic [31:0] newV,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = oldV;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = newV[8*b +: 8];
      end
    end
    return res;
  endfunction

  // The whole next state is built here from the registered copy; every field
  // except adcTrig, which defaults to 0, keeps its value unless a branch below gives it a new one.
  always_comb begin
    logic        doWrite;
    logic        idle;
    logic        ok;
    logic [31:0] clrFirst;
    logic [31:0] clrSecond;
    logic [31:0] setSecond;
    logic        smpEvent;
    logic        digOk;
    logic        anaOk;
    logic [2:0]  sel;
    logic [31:0] portWord;
    doWrite   = 1'b0;
    ok        = 1'b1;
    clrFirst  = '0;
    clrSecond = '0;
    setSecond = '0;
    smpEvent  = 1'b0;
    // Phase completion flags default to done outside the settle phase.
    digOk     = 1'b1;
    anaOk     = 1'b1;
    d         = q;
    d.adcTrig = 1'b0;
    idle      = (q.seq == lpsw_pkg::SEQ_IDLE);
    sel       = {q.selHi, q.selLo};
    portWord  = 32'(q.captured);

    // Port pins cross into sys_clk through two flip-flops.
    d.portMeta = portIn;
    d.portSync = q.portMeta;

    // Write channel: address and data may arrive in either order.
    // A pending response holds back the next write, so a slow bready
    // never loses a response code.
    if (axiReq.awvalid && !q.awHeld) begin
      d.awHeld = 1'b1;
      d.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && !q.wHeld) begin
      d.wHeld = 1'b1;
      d.wData = axiReq.wdata;
      d.wStrb = axiReq.wstrb;
    end
    if (q.bValid && axiReq.bready) begin
      d.bValid = 1'b0;
    end
    if (q.awHeld && q.wHeld && !q.bValid) begin
      doWrite  = 1'b1;
      d.awHeld = 1'b0;
      d.wHeld  = 1'b0;
      d.bValid = 1'b1;
    end

    if (doWrite) begin
      unique case (q.awAddr)
        `LPSW_OFF_STAB: begin
          if (idle && q.wStrb[1]) begin
            d.stabCount = q.wData[`LPSW_BIT_COUNT_LO +: 8];
          end
        end
        `LPSW_OFF_SEQ: begin
          if (q.wStrb[0]) begin
            if (idle) begin
              d.selHi = q.wData[`LPSW_BIT_SEL_HI];
              d.selLo = q.wData[`LPSW_BIT_SEL_LO +: 2];
            end
            d.digEn = q.wData[`LPSW_BIT_DIG_EN];
            d.anaEn = q.wData[`LPSW_BIT_ANA_EN];
          end
        end
        `LPSW_OFF_MASK1:  d.maskFirst  = merge(q.maskFirst, q.wData, q.wStrb);
        `LPSW_OFF_MASK2:  d.maskSecond = merge(q.maskSecond, q.wData, q.wStrb);
        `LPSW_OFF_CLR1:   clrFirst  = merge('0, q.wData, q.wStrb);
        `LPSW_OFF_CLR2:   clrSecond = merge('0, q.wData, q.wStrb);
        `LPSW_OFF_HOLD1: begin
          if (q.wStrb[0]) begin
            d.holdFirst = q.wData[0];
          end
        end
        `LPSW_OFF_HOLD2: begin
          if (q.wStrb[0]) begin
            d.holdSecond = q.wData[0];
          end
        end
        `LPSW_OFF_PSC: begin
          if (q.wStrb[0] && q.wData[0]) begin
            d.deep_stop_mode   = 1'b1;
            d.holdFirst  = 1'b1;
            d.holdSecond = 1'b1;
          end
        end
        `LPSW_OFF_EXPECT: begin
          d.expected = `LPSW_PORT_W'(merge(32'(q.expected), q.wData, q.wStrb));
        end
        `LPSW_OFF_OPST, `LPSW_OFF_FACT1, `LPSW_OFF_FACT2, `LPSW_OFF_CAPT: ;
        default: ok = 1'b0;
      endcase
      d.bResp = ok ? `LPSW_RESP_OKAY : `LPSW_RESP_SLVERR;
    end

    // Read channel: one outstanding read, answered the cycle after it is taken.
    // Read data is registered, so it stands unchanged until rready.
    if (q.rValid && axiReq.rready) begin
      d.rValid = 1'b0;
    end
    if (axiReq.arvalid && !q.rValid) begin
      d.rValid = 1'b1;
      d.rResp  = `LPSW_RESP_OKAY;
      unique case (axiReq.araddr)
        `LPSW_OFF_STAB:   d.rData = {16'h0000, q.stabCount, 8'h00};
        `LPSW_OFF_SEQ:    d.rData = {24'h00_0000, q.selHi, 3'h0, q.selLo,
                                     q.digEn, q.anaEn};
        `LPSW_OFF_OPST:   d.rData = {25'h000_0000, q.unexpected, q.mismatch,
                                     q.adcStarted, q.digDone, q.seq, !idle};
        `LPSW_OFF_MASK1:  d.rData = q.maskFirst;
        `LPSW_OFF_MASK2:  d.rData = q.maskSecond;
        `LPSW_OFF_FACT1:  d.rData = q.factFirst;
        `LPSW_OFF_FACT2:  d.rData = q.factSecond;
        `LPSW_OFF_HOLD1:  d.rData = {31'h0000_0000, q.holdFirst};
        `LPSW_OFF_HOLD2:  d.rData = {31'h0000_0000, q.holdSecond};
        `LPSW_OFF_PSC:    d.rData = {31'h0000_0000, q.deep_stop_mode};
        `LPSW_OFF_EXPECT: d.rData = 32'(q.expected);
        `LPSW_OFF_CAPT:   d.rData = portWord;
        `LPSW_OFF_CLR1, `LPSW_OFF_CLR2: d.rData = '0;
        default: begin
          d.rData = '0;
          d.rResp = `LPSW_RESP_SLVERR;
        end
      endcase
    end

    // Sequencer.
    // Idle waits for an enable, armed waits for the selected timer channel,
    // and settle powers the sensors until every enabled phase has finished.
    // Clearing both enables drops back to idle from any state.
    unique case (q.seq)
      lpsw_pkg::SEQ_IDLE: begin
        // arms once an enable is set
        if (d.digEn || d.anaEn) begin
          d.seq = lpsw_pkg::SEQ_ARMED;
        end
      end
      lpsw_pkg::SEQ_ARMED: begin
        if (!q.digEn && !q.anaEn) begin
          d.seq = lpsw_pkg::SEQ_IDLE;
        end else if (timerTrig[sel]) begin
          d.seq         = lpsw_pkg::SEQ_SETTLE;
          d.digDone     = 1'b0;
          d.adcStarted  = 1'b0;
          d.adcDoneSeen = 1'b0;
          d.mismatch    = 1'b0;
          d.unexpected  = 1'b0;
          d.oscDiv      = '0;
          d.ticks       = '0;
          d.elapsed     = '0;
        end
      end
      lpsw_pkg::SEQ_SETTLE: begin
        if (q.elapsed != {`LPSW_CNT_W{1'b1}}) begin
          d.elapsed = q.elapsed + 1'b1;
        end
        if (q.oscDiv == TICK_T) begin
          d.oscDiv = '0;
          if (q.ticks != 16'hFFFF) begin
            d.ticks = q.ticks + 16'h0001;
          end
        end else begin
          d.oscDiv = q.oscDiv + 16'h0001;
        end
        if (q.digEn && !q.digDone && q.elapsed >= DIG_T) begin
          d.digDone  = 1'b1;
          d.captured = q.portSync;
          d.mismatch = (q.portSync != q.expected);
        end
        if (q.anaEn && !q.adcStarted &&
            q.ticks >= {4'h0, q.stabCount, `LPSW_STAB_SHIFT'h0}) begin
          d.adcStarted = 1'b1;
          d.adcTrig    = 1'b1;
        end
        if (q.adcStarted && !q.adcDoneSeen && adcDone) begin
          d.adcDoneSeen = 1'b1;
          d.unexpected  = adcUnexpected;
        end
        digOk = !q.digEn || q.digDone;
        anaOk = !q.anaEn || q.adcDoneSeen;
        if (!q.digEn && !q.anaEn) begin
          d.seq = lpsw_pkg::SEQ_IDLE;
        end else if (digOk && anaOk) begin
          d.seq    = lpsw_pkg::SEQ_ARMED;
          smpEvent = q.mismatch || q.unexpected;
        end
      end
      default: d.seq = lpsw_pkg::SEQ_IDLE;
    endcase

    // The supply outputs are computed from the next state so that they rise
    // on the same edge that enters the settle phase.
    // supply follows settle phase
    d.digPwr = (d.seq == lpsw_pkg::SEQ_SETTLE) && d.digEn;
    d.anaPwr = (d.seq == lpsw_pkg::SEQ_SETTLE) && d.anaEn;

    for (int x = 0; x < `LPSW_SG_N; x++) begin
      setSecond[`LPSW_SG_FIRST + x] = scanGroupEndIrq[x] &&
                                      !q.maskSecond[`LPSW_SG_FIRST + x];
    end

    // A new event wins over a clear written in the same cycle.
    d.factFirst  = q.factFirst & ~clrFirst;
    d.factSecond = (q.factSecond & ~clrSecond) | setSecond;
    if (smpEvent && !q.maskFirst[`LPSW_BIT_SMP_WAKE]) begin
      d.factFirst[`LPSW_BIT_SMP_WAKE] = 1'b1;
    end
    // Any newly latched factor leaves deep stop, even against a power save
    // write in the same cycle, so a wake event is never lost.
    if ((d.factFirst & ~q.factFirst) != '0 || setSecond != '0) begin
      d.deep_stop_mode = 1'b0;
    end
  end

  // Reset clears everything except the wake masks, which start fully masked
  // so that no factor can wake the chip before software has set them.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q            <= '0;
      q.seq        <= lpsw_pkg::SEQ_IDLE;
      q.maskFirst  <= `LPSW_MASK_RESET;
      q.maskSecond <= `LPSW_MASK_RESET;
    end else begin
      q <= d;
    end
  end

  assign axiRsp.awready  = !q.awHeld;
  assign axiRsp.wready   = !q.wHeld;
  assign axiRsp.bvalid   = q.bValid;
  assign axiRsp.bresp    = q.bResp;
  assign axiRsp.arready  = !q.rValid;
  assign axiRsp.rvalid   = q.rValid;
  assign axiRsp.rdata    = q.rData;
  assign axiRsp.rresp    = q.rResp;
  assign digitalPowerOut = q.digPwr;
  assign analogPowerOut  = q.anaPwr;
  assign adcTrigger      = q.adcTrig;
  assign deepStopMode    = q.deep_stop_mode;
  assign ioHoldFirst     = q.holdFirst;
  assign ioHoldSecond    = q.holdSecond;
  assign wakeRequest     = (q.factFirst != '0) || (q.factSecond != '0);

endmodule // lpsw_top

`default_nettype wire

// ===== tb/lpsw_properties.sv
// Port-level checks of the low-power port sampler.
// Assumes a bind into lpsw_top; one clock, synchronous reset.
`timescale 1ns/1ns
`default_nettype none

module lpsw_properties #(
  parameter int DIG_STAB_CYC = 6250
) (
  input wire logic                    sys_clk,
  input wire logic                    srst,
  input wire lpsw_pkg::lpsw_axi_req_t axiReq,
  input wire lpsw_pkg::lpsw_axi_rsp_t axiRsp,
  input wire logic                    digitalPowerOut,
  input wire logic                    analogPowerOut,
  input wire logic                    adcTrigger,
  input wire logic                    deepStopMode,
  input wire logic                    ioHoldFirst,
  input wire logic                    ioHoldSecond,
  input wire logic                    wakeRequest
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic [15:0] onCnt_q;
  always_ff @(posedge sys_clk) begin
    if (srst || !digitalPowerOut) begin
      onCnt_q <= 16'h0000;
    end else begin
      onCnt_q <= onCnt_q + 16'h0001;
    end
  end
  reset_quiet_a: assert property (
    $fell(srst) |-> !digitalPowerOut && !analogPowerOut && !deepStopMode && !wakeRequest)
    else $error("outputs active after reset");
  trig_pulse_a: assert property (adcTrigger |=> !adcTrigger)
    else $error("trigger longer than one cycle");
  trig_powered_a: assert property (adcTrigger |-> analogPowerOut)
    else $error("trigger without analog supply");
  dig_settle_a: assert property (
    $fell(digitalPowerOut) |-> onCnt_q >= DIG_STAB_CYC - 1)
    else $error("digital supply dropped early");
  wake_exit_a: assert property ($rose(wakeRequest) |-> !deepStopMode)
    else $error("wake left deep stop set");
  hold_entry_a: assert property ($rose(deepStopMode) |-> ioHoldFirst && ioHoldSecond)
    else $error("holds not set on deep stop");
  write_answer_a: assert property (
    axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready |=> ##1 axiRsp.bvalid)
    else $error("write response late");
  resp_stands_a: assert property (
    axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp))
    else $error("write response dropped");
  read_answer_a: assert property (
    axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("read data late");
  read_stands_a: assert property (
    axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata))
    else $error("read data not held");
endmodule // lpsw_properties

`default_nettype wire

// ===== tb/lpsw_partner.sv
// Sensors, interval timer and A/D converter around the sampler.
// Assumes the bench requests timer and scan-group pulses on sys_clk.
`include "lpsw_params.svh"
`timescale 1ns/1ns
`default_nettype none

module lpsw_partner (
  input  wire logic                    sys_clk,
  input  wire logic                    srst,
  input  wire logic                    tick,
  input  wire logic [2:0]              tickCh,
  input  wire logic [`LPSW_PORT_W-1:0] portLevel,
  input  wire logic                    badVolt,
  input  wire logic [7:0]              adcLat,
  input  wire logic [`LPSW_SG_N-1:0]   sgPulse,
  input  wire logic                    digitalPowerOut,
  input  wire logic                    analogPowerOut,
  input  wire logic                    adcTrigger,
  output logic      [`LPSW_TMR_N-1:0]  timerTrig,
  output logic      [`LPSW_PORT_W-1:0] portIn,
  output logic                         adcDone,
  output logic                         adcUnexpected,
  output logic      [`LPSW_SG_N-1:0]   scanGroupEndIrq
);
  logic       convBusy;
  logic [7:0] convWait;
  // sensors unpowered: Unsupplied sensors show the inverted level.
  assign portIn = (digitalPowerOut || analogPowerOut) ? portLevel : ~portLevel;
  always_ff @(posedge sys_clk) begin
    timerTrig <= tick ? (8'(1) << tickCh) : 8'h00;
    scanGroupEndIrq <= sgPulse;
    adcDone <= 1'b0;
    adcUnexpected <= ~adcUnexpected;
    if (srst) begin
      convBusy <= 1'b0;
      convWait <= 8'h00;
      adcUnexpected <= 1'b0;
    end else if (adcTrigger) begin
      convBusy <= 1'b1;
      convWait <= adcLat;
    end else if (convBusy && convWait == 8'h00) begin
      adcDone <= 1'b1;
      adcUnexpected <= badVolt;
      convBusy <= 1'b0;
    end else if (convBusy) begin
      convWait <= convWait - 8'h01;
    end
  end
endmodule // lpsw_partner

`default_nettype wire

// ===== tb/lpsw_tb_top.sv
// Self-checking bench of the port sampler with its sensor and timer model.
// Assumes lpsw_pkg and lpsw_params.svh compiled first.
`include "lpsw_params.svh"
`timescale 1ns/1ns
`default_nettype none

module lpsw_tb_top;
  localparam int DIG_STAB_CYC = 20;
  localparam int OSC_TICK_CYC = 2;
  logic                    sys_clk;
  logic                    srst;
  lpsw_pkg::lpsw_axi_req_t axiReq;
  lpsw_pkg::lpsw_axi_rsp_t axiRsp;
  logic [23:0]             portIn;
  logic [23:0]             portLevel;
  logic [7:0]              timerTrig;
  logic [4:0]              sgIrq;
  logic [4:0]              sgPulse;
  logic                    adcDone;
  logic                    adcBad;
  logic                    badVolt;
  logic                    tick;
  logic [2:0]              tickCh;
  logic                    digPwr;
  logic                    anaPwr;
  logic                    adcTrig;
  logic                    deep_stop_mode;
  logic [1:0]              holds;
  logic                    wake;
  int                      failures;
  int                      totalChecks;

  lpsw_top #(.DIG_STAB_CYC(DIG_STAB_CYC), .OSC_TICK_CYC(OSC_TICK_CYC)) dut_u (
    .sys_clk(sys_clk), .srst(srst), .axiReq(axiReq), .axiRsp(axiRsp), .portIn(portIn),
    .timerTrig(timerTrig), .adcDone(adcDone), .adcUnexpected(adcBad),
    .scanGroupEndIrq(sgIrq), .digitalPowerOut(digPwr), .analogPowerOut(anaPwr),
    .adcTrigger(adcTrig), .deepStopMode(deep_stop_mode), .ioHoldFirst(holds[1]),
    .ioHoldSecond(holds[0]), .wakeRequest(wake));
  lpsw_partner partner_u (
    .sys_clk(sys_clk), .srst(srst), .tick(tick), .tickCh(tickCh), .portLevel(portLevel),
    .badVolt(badVolt), .adcLat(8'h1E), .sgPulse(sgPulse), .digitalPowerOut(digPwr),
    .analogPowerOut(anaPwr), .adcTrigger(adcTrig), .timerTrig(timerTrig), .portIn(portIn),
    .adcDone(adcDone), .adcUnexpected(adcBad), .scanGroupEndIrq(sgIrq));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic give_verdict;
    if (failures == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Both channels offered together; each released at the edge that takes it.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw, w, b;
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hF;
    axiReq.bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge sys_clk);
      aw = axiReq.awvalid && axiRsp.awready;
      w = axiReq.wvalid && axiRsp.wready;
      b = axiRsp.bvalid;
      @(posedge sys_clk);
      if (aw) axiReq.awvalid <= 1'b0;
      if (w) axiReq.wvalid <= 1'b0;
      if (b) axiReq.bready <= 1'b0;
      if (b) break;
    end
    // Let an edge pass so a following call does not redrive bready now.
    @(posedge sys_clk);
    if (n == 50) failures++;
    if (n == 50) give_verdict();
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar, rv;
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge sys_clk);
      ar = axiReq.arvalid && axiRsp.arready;
      rv = axiRsp.rvalid;
      d = axiRsp.rdata;
      r = axiRsp.rresp;
      @(posedge sys_clk);
      if (ar) axiReq.arvalid <= 1'b0;
      if (rv) axiReq.rready <= 1'b0;
      if (rv) break;
    end
    // Let an edge pass so a following call does not redrive rready now.
    @(posedge sys_clk);
    if (n == 50) failures++;
    if (n == 50) give_verdict();
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d, exp);
  endtask

  // One timer-started cycle; indices are cycles after the timer request.
  task automatic run_cycle(input logic [2:0] ch, output int onAt, output int trigAt,
                           output int offAt);
    int n;
    tick <= 1'b1;
    tickCh <= ch;
    @(posedge sys_clk);
    tick <= 1'b0;
    onAt = -1;
    trigAt = -1;
    for (n = 0; n < 3000; n++) begin
      @(negedge sys_clk);
      if ((digPwr || anaPwr) && onAt < 0) onAt = n;
      if (adcTrig && trigAt < 0) trigAt = n;
      offAt = n;
      if (onAt >= 0 && !(digPwr || anaPwr)) break;
    end
    if (n == 3000) failures++;
    if (n == 3000) give_verdict();
    @(posedge sys_clk);
  endtask

  task automatic check_reset_map;
    logic [31:0] d;
    logic [1:0] r;
    rd_chk(`LPSW_OFF_SEQ, 32'h0000_0000);
    rd_chk(`LPSW_OFF_OPST, 32'h0000_0000);
    rd_chk(`LPSW_OFF_MASK1, 32'hFFFF_FFFF);
    rd_chk(`LPSW_OFF_MASK2, 32'hFFFF_FFFF);
    axi_wr(`LPSW_OFF_OPST, 32'h0000_007F);
    rd_chk(`LPSW_OFF_OPST, 32'h0000_0000);
    axi_rd(8'h3C, d, r);
    chk({d[1:0], r}, {2'h0, `LPSW_RESP_SLVERR});
  endtask

  task automatic check_digital;
    logic [31:0] d;
    logic [1:0] r;
    int onAt, trigAt, offAt;
    axi_wr(`LPSW_OFF_STAB, 32'h0000_0300);
    axi_wr(`LPSW_OFF_EXPECT, {8'h00, portLevel});
    axi_wr(`LPSW_OFF_MASK1, 32'hFFFF_FFFD);
    axi_wr(`LPSW_OFF_SEQ, 32'h0000_0086);
    rd_chk(`LPSW_OFF_SEQ, 32'h0000_0086);
    axi_rd(`LPSW_OFF_OPST, d, r);
    chk(d[2:1], 2'h1);
    // busy-time write is the refused case here.
    axi_wr(`LPSW_OFF_STAB, 32'h0000_0500);
    rd_chk(`LPSW_OFF_STAB, 32'h0000_0300);
    axi_wr(`LPSW_OFF_PSC, 32'h0000_0001);
    tick <= 1'b1;
    tickCh <= 3'h4;
    @(posedge sys_clk);
    tick <= 1'b0;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({deep_stop_mode, holds, digPwr}, 4'hE);
    @(posedge sys_clk);
    run_cycle(3'h5, onAt, trigAt, offAt);
    chk(offAt - onAt >= DIG_STAB_CYC && offAt - onAt <= DIG_STAB_CYC + 10, 1);
    chk({trigAt < 0, wake, deep_stop_mode}, 3'h5);
    rd_chk(`LPSW_OFF_CAPT, {8'h00, portLevel});
    portLevel <= 24'h5A_A5C3;
    run_cycle(3'h5, onAt, trigAt, offAt);
    chk({wake, deep_stop_mode}, 2'h2);
    rd_chk(`LPSW_OFF_FACT1, 32'h0000_0002);
    axi_wr(`LPSW_OFF_CLR1, 32'h0000_0002);
    rd_chk(`LPSW_OFF_FACT1, 32'h0000_0000);
    axi_wr(`LPSW_OFF_HOLD1, 32'h0000_0000);
    axi_wr(`LPSW_OFF_HOLD2, 32'h0000_0000);
    @(negedge sys_clk);
    chk({wake, holds}, 3'h0);
    @(posedge sys_clk);
  endtask

  task automatic check_mixed;
    int onAt, trigAt, offAt;
    portLevel <= 24'hA5_5A3C;
    badVolt <= 1'b1;
    axi_wr(`LPSW_OFF_SEQ, 32'h0000_0000);
    axi_wr(`LPSW_OFF_MASK1, 32'hFFFF_FFFF);
    axi_wr(`LPSW_OFF_SEQ, 32'h0000_0086);
    axi_wr(`LPSW_OFF_SEQ, 32'h0000_0087);
    run_cycle(3'h5, onAt, trigAt, offAt);
    chk(trigAt >= 3 * 16 * OSC_TICK_CYC - 2 && trigAt <= 3 * 16 * OSC_TICK_CYC + 8, 1);
    chk({offAt > trigAt + 30, wake}, 2'h2);
    axi_wr(`LPSW_OFF_MASK1, 32'hFFFF_FFFD);
    run_cycle(3'h5, onAt, trigAt, offAt);
    chk(wake, 1'b1);
    rd_chk(`LPSW_OFF_FACT1, 32'h0000_0002);
    axi_wr(`LPSW_OFF_CLR1, 32'h0000_0002);
    badVolt <= 1'b0;
  endtask

  task automatic check_scan_groups;
    axi_wr(`LPSW_OFF_MASK2, 32'hFFFF_BFFF);
    sgPulse <= 5'h03;
    @(posedge sys_clk);
    sgPulse <= 5'h00;
    repeat (3) @(posedge sys_clk);
    rd_chk(`LPSW_OFF_FACT2, 32'h0000_4000);
    axi_wr(`LPSW_OFF_CLR2, 32'h0000_4000);
    rd_chk(`LPSW_OFF_FACT2, 32'h0000_0000);
  endtask

  initial begin
    srst = 1'b1;
    axiReq = '0;
    portLevel = 24'hA5_5A3C;
    badVolt = 1'b0;
    tick = 1'b0;
    tickCh = 3'h0;
    sgPulse = 5'h00;
    failures = 0;
    totalChecks = 0;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    check_reset_map();
    check_digital();
    check_mixed();
    check_scan_groups();
    give_verdict();
  end
endmodule // lpsw_tb_top

bind lpsw_top lpsw_properties #(.DIG_STAB_CYC(DIG_STAB_CYC)) lpsw_chk_u (
  .sys_clk(sys_clk), .srst(srst), .axiReq(axiReq), .axiRsp(axiRsp),
  .digitalPowerOut(digitalPowerOut), .analogPowerOut(analogPowerOut),
  .adcTrigger(adcTrigger), .deepStopMode(deepStopMode), .ioHoldFirst(ioHoldFirst),
  .ioHoldSecond(ioHoldSecond), .wakeRequest(wakeRequest));

`default_nettype wire
